// ### rtl/lcdaux_decoder.sv
// Device end: decodes auxiliary command bytes and drives the panel control outputs.
`timescale 1ns/100ps
`include "lcdaux_defs.svh"
// Summary of operation
// - Volume mode accepts only the next byte
// - Low six bits load drive level
// - Leave volume mode after storing level
// - Host sends volume bytes back to back
// - Host writes 100000 if unused
// - Indicator off single byte, on starts pair
// - Indicator pending accepts only register byte
// - Host follows indicator on with register
// - Low two bits pick blink mode
// - Only indicator commands and software reset change indicator
// - Power save bit0 selects standby or sleep
// - Settings and memory kept in power save
// - Sleep stops oscillator, supply and drivers
// - Standby stops supply, keeps indicator drive
// - Display-off output low in power save
// - System cuts external supplies using output
// - Exit command restores prior operating state
// - Nibble stores reversal line count
// - N-line reset keeps count, normal alternation
// - Oscillator on only master with internal
// - Software reset reinitializes level and indicator
module lcdaux_decoder
(
   input  wire logic              mclk,
   input  wire logic              rst,
   lcdaux_if.dev                  port,
   input  wire logic              master_strap,
   input  wire logic              clock_source_strap,
   output logic [5:0]             lcd_drive_level,
   output logic [1:0]             indicator_mode,
   output logic                   indicator_electrode_b,
   output logic [3:0]             reversal_line_count,
   output logic                   nline_enable,
   output logic                   osc_run,
   output logic                   drive_supply_on,
   output logic                   mux_drive_on,
   output logic                   seg_com_at_supply,
   output logic                   display_off_out,
   output logic                   dec_busy
);
   // ****************************************************************
   // Write strobe capture
   // ****************************************************************
   logic                       wr_n_reg;
   lcdaux_pkg::lcdaux_state_t  state_reg;
   lcdaux_pkg::lcdaux_state_t  state_next;
   lcdaux_pkg::lcdaux_psave_t  psave_reg;
   lcdaux_pkg::lcdaux_psave_t  psave_next;
   logic [5:0]                 vol_reg;
   logic [5:0]                 vol_next;
   logic [1:0]                 ind_reg;
   logic [1:0]                 ind_next;
   logic [3:0]                 nline_reg;
   logic [3:0]                 nline_next;
   logic                       nline_on_reg;
   logic                       nline_on_next;
   logic                       osc_reg;
   logic                       osc_next;
   logic [24:0]                blink_cnt_reg;
   logic [24:0]                blink_cnt_next;
   logic                       blink_reg;
   logic                       blink_next;
   logic                       cmd_wr;
   logic [7:0]                 b;
   logic                       normal;
   logic                       is_ind;
   logic                       is_psave;
   logic                       is_nline;
   logic [24:0]                blink_lim;

   // Masked compare of a command byte against one command family.
   function automatic logic cmd_match
   (
      input logic [7:0] v,
      input logic [7:0] mask,
      input logic [7:0] code
   );
      return ((v & mask) == code);
   endfunction : cmd_match

   // A command byte is taken on the rising edge of the write strobe with select low.
   assign cmd_wr = port.wr_n && !wr_n_reg && !port.cmd_data_select;
   assign b      = port.data;
   assign normal = (state_reg == lcdaux_pkg::LCDAUX_NORMAL);
   assign is_ind   = cmd_match(b, `LCDAUX_CMD_IND_MASK, `LCDAUX_CMD_IND);
   assign is_psave = cmd_match(b, `LCDAUX_CMD_PSAVE_MASK, `LCDAUX_CMD_PSAVE);
   assign is_nline = cmd_match(b, `LCDAUX_CMD_NLINE_MASK, `LCDAUX_CMD_NLINE);

   // ****************************************************************
   // Command decode
   // ****************************************************************
   // Next-state decode; codes that match nothing leave every setting as it is.
   always_comb
   begin
      state_next    = state_reg;
      psave_next    = psave_reg;
      vol_next      = vol_reg;
      ind_next      = ind_reg;
      nline_next    = nline_reg;
      nline_on_next = nline_on_reg;
      osc_next      = osc_reg;
      if (cmd_wr)
      begin
         unique case (state_reg)
            lcdaux_pkg::LCDAUX_VOL_PEND:
            begin
               vol_next   = b[5:0];
               state_next = lcdaux_pkg::LCDAUX_NORMAL;
            end
            lcdaux_pkg::LCDAUX_IND_PEND:
            begin
               ind_next   = b[1:0];
               state_next = lcdaux_pkg::LCDAUX_NORMAL;
            end
            lcdaux_pkg::LCDAUX_NORMAL:
            begin
               if (b == `LCDAUX_CMD_VOL_MODE)
                  state_next = lcdaux_pkg::LCDAUX_VOL_PEND;
               else if (is_ind && b[0])
                  state_next = lcdaux_pkg::LCDAUX_IND_PEND;
               else if (is_ind)
                  ind_next = `LCDAUX_IND_RST;
               else if (is_psave)
                  psave_next = b[0] ? lcdaux_pkg::LCDAUX_PS_SLEEP : lcdaux_pkg::LCDAUX_PS_STANDBY;
               else if (b == `LCDAUX_CMD_PSAVE_EXIT)
                  psave_next = lcdaux_pkg::LCDAUX_PS_RUN;
               else if (is_nline)
               begin
                  nline_next    = b[3:0];
                  nline_on_next = (b[3:0] != 4'h0);
               end
               else if (b == `LCDAUX_CMD_NLINE_RST)
                  nline_on_next = 1'b0;
               else if (b == `LCDAUX_CMD_OSC_ON)
                  osc_next = osc_reg | (master_strap & clock_source_strap);
               else if (b == `LCDAUX_CMD_SW_RESET)
               begin
                  vol_next = `LCDAUX_VOL_RST;
                  ind_next = `LCDAUX_IND_RST;
               end
            end
            default:
               state_next = lcdaux_pkg::LCDAUX_NORMAL;
         endcase
      end
   end

   // ****************************************************************
   // Indicator blink timer
   // ****************************************************************
   // Toggle period follows the stored blink mode.
   assign blink_lim = (ind_reg == 2'h1) ? 25'(`LCDAUX_BLINK_FAST_CYC / 2 - 1)
                                        : 25'(`LCDAUX_BLINK_SLOW_CYC / 2 - 1);
   assign blink_cnt_next = (blink_cnt_reg >= blink_lim) ? 25'h0 : blink_cnt_reg + 25'h1;
   assign blink_next     = (blink_cnt_reg >= blink_lim) ? !blink_reg : blink_reg;

   // State registers; hardware reset clears any pending pair.
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         wr_n_reg      <= 1'b1;
         state_reg     <= lcdaux_pkg::LCDAUX_NORMAL;
         psave_reg     <= lcdaux_pkg::LCDAUX_PS_RUN;
         vol_reg       <= `LCDAUX_VOL_RST;
         ind_reg       <= `LCDAUX_IND_RST;
         nline_reg     <= `LCDAUX_NLINE_RST;
         nline_on_reg  <= 1'b0;
         osc_reg       <= 1'b0;
         blink_cnt_reg <= 25'h0;
         blink_reg     <= 1'b0;
      end
      else
      begin
         wr_n_reg      <= port.wr_n;
         state_reg     <= state_next;
         psave_reg     <= psave_next;
         vol_reg       <= vol_next;
         ind_reg       <= ind_next;
         nline_reg     <= nline_next;
         nline_on_reg  <= nline_on_next;
         osc_reg       <= osc_next;
         blink_cnt_reg <= blink_cnt_next;
         blink_reg     <= blink_next;
      end
   end

   // ****************************************************************
   // Panel control outputs
   // ****************************************************************
   // Power save gates the drive without touching the stored settings.
   assign lcd_drive_level       = vol_reg;
   assign indicator_mode        = ind_reg;
   assign reversal_line_count   = nline_reg;
   assign nline_enable          = nline_on_reg;
   assign osc_run               = osc_reg && (psave_reg != lcdaux_pkg::LCDAUX_PS_SLEEP);
   assign drive_supply_on       = (psave_reg == lcdaux_pkg::LCDAUX_PS_RUN);
   assign mux_drive_on          = (psave_reg == lcdaux_pkg::LCDAUX_PS_RUN);
   assign seg_com_at_supply     = (psave_reg != lcdaux_pkg::LCDAUX_PS_RUN);
   assign display_off_out       = (psave_reg == lcdaux_pkg::LCDAUX_PS_RUN);
   assign indicator_electrode_b = (psave_reg != lcdaux_pkg::LCDAUX_PS_SLEEP) &&
                                  ((ind_reg == 2'h3) || (ind_reg != 2'h0 && blink_reg));
   assign dec_busy              = !normal;
endmodule : lcdaux_decoder

// ### rtl/lcdaux_defs.svh
// Command codes, field widths, reset values and timing counts of the auxiliary command decoder.
`ifndef LCDAUX_DEFS_SVH
`define LCDAUX_DEFS_SVH
`define LCDAUX_CMD_VOL_MODE     8'h81
`define LCDAUX_CMD_IND_MASK     8'hFE
`define LCDAUX_CMD_IND          8'hAC
`define LCDAUX_CMD_PSAVE_MASK   8'hFE
`define LCDAUX_CMD_PSAVE        8'hA8
`define LCDAUX_CMD_PSAVE_EXIT   8'hE1
`define LCDAUX_CMD_NLINE_MASK   8'hF0
`define LCDAUX_CMD_NLINE        8'h30
`define LCDAUX_CMD_NLINE_RST    8'hE4
`define LCDAUX_CMD_OSC_ON       8'hAB
`define LCDAUX_CMD_SW_RESET     8'hE2
`define LCDAUX_VOL_W            6
`define LCDAUX_IND_W            2
`define LCDAUX_NLINE_W          4
`define LCDAUX_VOL_RST          6'h20
`define LCDAUX_IND_RST          2'h0
`define LCDAUX_NLINE_RST        4'h0
`define LCDAUX_VOL_UNUSED       8'h20
`define LCDAUX_BLINK_FAST_MS    500
`define LCDAUX_BLINK_SLOW_MS    1000
`define LCDAUX_CLK_KHZ          20000
`define LCDAUX_BLINK_FAST_CYC   (`LCDAUX_BLINK_FAST_MS * `LCDAUX_CLK_KHZ)
`define LCDAUX_BLINK_SLOW_CYC   (`LCDAUX_BLINK_SLOW_MS * `LCDAUX_CLK_KHZ)
`define LCDAUX_REG_CMD          32'h0000_0000
`define LCDAUX_REG_STATUS       32'h0000_0004
`define LCDAUX_REG_SETTINGS     32'h0000_0008
`endif

// ### rtl/lcdaux_pkg.sv
// Types used by the device end of the auxiliary command link.
package lcdaux_pkg;
   // One-hot decoder states.
   typedef enum logic [2:0]
   {
      LCDAUX_NORMAL  = 3'b001,
      LCDAUX_VOL_PEND = 3'b010,
      LCDAUX_IND_PEND = 3'b100
   } lcdaux_state_t;
   // Power save condition.
   typedef enum logic [1:0]
   {
      LCDAUX_PS_RUN     = 2'h0,
      LCDAUX_PS_STANDBY = 2'h1,
      LCDAUX_PS_SLEEP   = 2'h2
   } lcdaux_psave_t;
endpackage : lcdaux_pkg

// ### rtl/lcdaux_if.sv
// Parallel command port between host processor and auxiliary command decoder.
`timescale 1ns/100ps
interface lcdaux_if;
   logic       cmd_data_select;
   logic       wr_n;
   logic [7:0] data;
   modport host
   (
      output cmd_data_select,
      output wr_n,
      output data
   );
   modport dev
   (
      input cmd_data_select,
      input wr_n,
      input data
   );
endinterface : lcdaux_if

// ### rtl/lcdaux_host.sv
// Host end: AHB-Lite slave that turns software writes into command port cycles.
`timescale 1ns/100ps
`include "lcdaux_defs.svh"
module lcdaux_host
(
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   lcdaux_if.host           port
);
   // ****************************************************************
   // Bus slave
   // ****************************************************************
   logic        ap_wr_reg;
   logic [31:0] ap_addr_reg;
   logic [1:0]  phase_reg;
   logic [7:0]  byte_reg;
   logic [31:0] hrdata_reg;
   logic [7:0]  last_reg;
   logic        pair_reg;
   logic        take;
   logic        is_cmd;
   logic        busy;
   logic        pair_open;

   // A write to the command word is stalled while a port cycle is in flight.
   assign take      = hsel && hready && htrans[1];
   assign busy      = (phase_reg != 2'h0);
   assign is_cmd    = ap_wr_reg && (ap_addr_reg == `LCDAUX_REG_CMD);
   assign hreadyout = !(is_cmd && busy);
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_reg;
   // A pair opener keeps the next byte bound to it.
   assign pair_open = (hwdata[7:0] == `LCDAUX_CMD_VOL_MODE) || (hwdata[7:0] == (`LCDAUX_CMD_IND | 8'h01));

   // Address phase capture, port sequencing and read data.
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         ap_wr_reg   <= 1'b0;
         ap_addr_reg <= 32'h0000_0000;
         phase_reg   <= 2'h0;
         byte_reg    <= 8'h00;
         hrdata_reg  <= 32'h0000_0000;
         last_reg    <= 8'h00;
         pair_reg    <= 1'b0;
      end
      else
      begin
         if (hreadyout)
         begin
            ap_wr_reg   <= take && hwrite;
            ap_addr_reg <= haddr; // Full decode, so no other word aliases onto the command word.
         end
         if (is_cmd && !busy)
         begin
            byte_reg  <= hwdata[7:0];
            last_reg  <= hwdata[7:0];
            pair_reg  <= pair_open && !pair_reg;
            phase_reg <= 2'h1;
         end
         else if (busy)
            phase_reg <= phase_reg + 2'h1;
         if (take && !hwrite && hreadyout)
            hrdata_reg <= (haddr == `LCDAUX_REG_STATUS) ? {30'h0, pair_reg, busy}
                        : (haddr == `LCDAUX_REG_SETTINGS) ? {24'h0, last_reg} : 32'h0000_0000;
      end
   end

   // ****************************************************************
   // Command port drive
   // ****************************************************************
   // Strobe low for two cycles, data and select held through the whole cycle.
   assign port.cmd_data_select = 1'b0;
   assign port.wr_n            = !(phase_reg == 2'h1 || phase_reg == 2'h2);
   assign port.data            = byte_reg;
endmodule : lcdaux_host

// ### test/lcdaux_asserts.sv
// Concurrent checks on the command port and the decoder outputs.
`timescale 1ns/100ps
module lcdaux_asserts
(
   input wire logic       mclk,
   input wire logic       rst,
   input wire logic       cmd_data_select,
   input wire logic       wr_n,
   input wire logic [7:0] data,
   input wire logic [5:0] lcd_drive_level,
   input wire logic [1:0] indicator_mode,
   input wire logic [3:0] reversal_line_count,
   input wire logic       nline_enable,
   input wire logic       osc_run,
   input wire logic       mux_drive_on,
   input wire logic       display_off_out,
   input wire logic       dec_busy,
   input wire logic       master_strap,
   input wire logic       clock_source_strap
);
   // ****************************************
   // Byte capture and pair tracking
   // ****************************************
   logic wr_q;
   logic pv;
   logic pi;
   wire  take = wr_n & ~wr_q & ~cmd_data_select;
   wire  cmd  = take & ~dec_busy;
   // Remembers the strobe level and which pair opener was last taken.
   always_ff @(posedge mclk or posedge rst)
      if (rst)
      begin
         wr_q <= 1'b1;
         pv   <= 1'b0;
         pi   <= 1'b0;
      end
      else
      begin
         wr_q <= wr_n;
         pv   <= take ? (cmd && data == 8'h81) : pv;
         pi   <= take ? (cmd && data == 8'hAD) : pi;
      end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   property p_vol_open; cmd && data == 8'h81 |=> dec_busy; endproperty
   property p_vol_load; take && pv |=> lcd_drive_level == $past(data[5:0]) && !dec_busy; endproperty
   property p_ind_off; cmd && data == 8'hAC |=> indicator_mode == 2'h0 && !dec_busy; endproperty
   property p_ind_load; take && pi |=> indicator_mode == $past(data[1:0]) && !dec_busy; endproperty
   property p_ind_hold; cmd && data[7:1] != 7'h56 && data != 8'hE2 |=> $stable(indicator_mode); endproperty
   property p_psave; cmd && data[7:1] == 7'h54 |=> !display_off_out && !mux_drive_on; endproperty
   property p_sleep; cmd && data == 8'hA9 |=> !osc_run; endproperty
   property p_exit; cmd && data == 8'hE1 |=> display_off_out && mux_drive_on; endproperty
   property p_nline; cmd && data[7:4] == 4'h3 |=> reversal_line_count == $past(data[3:0]); endproperty
   property p_nline_rst; cmd && data == 8'hE4 |=> !nline_enable && $stable(reversal_line_count); endproperty
   property p_osc; cmd && data == 8'hAB && !(master_strap && clock_source_strap) |=> $stable(osc_run); endproperty
   property p_swrst; cmd && data == 8'hE2 |=> lcd_drive_level == 6'h20 && indicator_mode == 2'h0; endproperty
   a_vol_open: assert property (p_vol_open) else $error("volume pair not opened");
   a_vol_load: assert property (p_vol_load) else $error("drive level not loaded");
   a_ind_off: assert property (p_ind_off) else $error("indicator not switched off");
   a_ind_load: assert property (p_ind_load) else $error("indicator mode not loaded");
   a_ind_hold: assert property (p_ind_hold) else $error("indicator changed by other command");
   a_psave: assert property (p_psave) else $error("power save not entered");
   a_sleep: assert property (p_sleep) else $error("oscillator runs in sleep");
   a_exit: assert property (p_exit) else $error("power save not left");
   a_nline: assert property (p_nline) else $error("line count not stored");
   a_nline_rst: assert property (p_nline_rst) else $error("n-line reset wrong");
   a_osc: assert property (p_osc) else $error("oscillator started without straps");
   a_swrst: assert property (p_swrst) else $error("software reset wrong");
   c_vol: cover property (take && pv);
   c_ind: cover property (take && pi);
   c_sleep: cover property (!display_off_out && !osc_run);
endmodule : lcdaux_asserts

// ### test/lcd_aux_command_decoder_tb.sv
// Bench joining host and decoder ends and driving software writes over AHB-Lite.
`timescale 1ns/100ps
`include "lcdaux_defs.svh"
module lcd_aux_command_decoder_tb;
   logic        mclk;
   logic        rst = 1'b1;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic [31:0] rd;
   logic        hreadyout, hresp, indicator_electrode_b, nline_enable, osc_run, drive_supply_on;
   logic        mux_drive_on, seg_com_at_supply, display_off_out, dec_busy;
   logic        master_strap = 1'b0;
   logic        clock_source_strap = 1'b0;
   logic [5:0]  lcd_drive_level;
   logic [1:0]  indicator_mode;
   logic [3:0]  reversal_line_count;
   logic [7:0]  vt [4] = '{8'hC5, 8'h3F, 8'hC0, 8'hA0};
   int          n_errors = 0;
   int          checked = 0;
   lcdaux_if    link ();
   lcdaux_host lcdaux_host_i (.mclk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
      .hrdata, .hreadyout, .hresp, .port(link.host));
   lcdaux_decoder lcdaux_decoder_i (.mclk, .rst, .port(link.dev), .master_strap, .clock_source_strap,
      .lcd_drive_level, .indicator_mode, .indicator_electrode_b, .reversal_line_count, .nline_enable, .osc_run,
      .drive_supply_on, .mux_drive_on, .seg_com_at_supply, .display_off_out, .dec_busy);
   lcdaux_asserts lcdaux_asserts_i (.mclk, .rst, .cmd_data_select(link.cmd_data_select), .wr_n(link.wr_n),
      .data(link.data), .lcd_drive_level, .indicator_mode, .reversal_line_count, .nline_enable, .osc_run,
      .mux_drive_on, .display_off_out, .dec_busy, .master_strap, .clock_source_strap);
   // ****************************************
   // Bus tasks and comparison
   // ****************************************
   task automatic results;
      $display("Mismatches %0d, comparisons %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : results
   task automatic fail;
      n_errors++;
      results();
   endtask : fail
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // Waits for the next edge with hready high, under a bound.
   task automatic wait_rdy;
      int k;
      k = 0;
      @(posedge mclk);
      while (hreadyout !== 1'b1)
      begin
         if (k++ > 50)
            fail();
         @(posedge mclk);
      end
   endtask : wait_rdy
   task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= 2'h2;
      hwrite <= w;
      wait_rdy();
      htrans <= 2'h0;
      hsel   <= 1'b0;
      hwdata <= d;
      wait_rdy();
      rd = hrdata;
   endtask : bus
   // Sends one command byte and waits until the port cycle has ended.
   task automatic cmd(input logic [7:0] b);
      int k;
      k = 0;
      bus(`LCDAUX_REG_CMD, 1'b1, {24'h0, b});
      rd = 32'h1;
      while (rd[0] !== 1'b0)
      begin
         if (k++ > 20)
            fail();
         bus(`LCDAUX_REG_STATUS, 1'b0, 32'h0);
      end
      repeat (2) @(posedge mclk);
   endtask : cmd
   // Free-running system clock.
   initial
   begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   // Main sequence.
   initial
   begin
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      chk(32'(lcd_drive_level), 32'h20);
      chk(32'(display_off_out), 32'h1);
      chk(32'(hresp), 32'h0);
      foreach (vt[j])
      begin
         cmd(8'h81);
         chk(32'(dec_busy), 32'h1);
         chk(rd, 32'h2);
         cmd(vt[j]);
         chk(rd, 32'h0);
         chk(32'(lcd_drive_level), 32'(vt[j][5:0]));
         chk(32'(dec_busy), 32'h0);
      end
      cmd(8'h81);
      cmd(8'hA9);
      chk(32'(lcd_drive_level), 32'h29);
      chk(32'(display_off_out), 32'h1);
      for (int m = 0; m < 4; m++)
      begin
         cmd(8'hAD);
         cmd({6'h2A, 2'(m)});
         chk(32'(indicator_mode), 32'(m));
      end
      chk(32'(indicator_electrode_b), 32'h1);
      cmd(8'hAD);
      cmd(8'h81);
      chk(32'(indicator_mode), 32'h1);
      chk(32'(dec_busy), 32'h0);
      cmd(8'hAC);
      chk(32'(indicator_mode), 32'h0);
      cmd(8'hAD);
      cmd(8'h03);
      cmd(8'hA4);
      chk(32'(indicator_mode), 32'h3);
      chk(32'(lcd_drive_level), 32'h29);
      cmd(8'hA8);
      chk(32'({display_off_out, mux_drive_on, drive_supply_on, seg_com_at_supply}), 32'h1);
      chk(32'(indicator_electrode_b), 32'h1);
      cmd(8'h81);
      cmd(8'h11);
      cmd(8'hE1);
      chk(32'({display_off_out, mux_drive_on, lcd_drive_level}), 32'hD1);
      cmd(8'hAB);
      chk(32'(osc_run), 32'h0);
      master_strap <= 1'b1;
      cmd(8'hAB);
      chk(32'(osc_run), 32'h0);
      clock_source_strap <= 1'b1;
      cmd(8'hAB);
      chk(32'(osc_run), 32'h1);
      cmd(8'hA9);
      chk(32'({osc_run, indicator_electrode_b, display_off_out, mux_drive_on}), 32'h0);
      cmd(8'hE1);
      chk(32'(osc_run), 32'h1);
      for (int m = 1; m < 16; m++)
      begin
         cmd({4'h3, 4'(m)});
         chk(32'({nline_enable, reversal_line_count}), 32'h10 | m);
      end
      cmd(8'hE4);
      chk(32'({nline_enable, reversal_line_count}), 32'h0F);
      cmd(8'h30);
      chk(32'({nline_enable, reversal_line_count}), 32'h00);
      bus(`LCDAUX_REG_SETTINGS, 1'b0, 32'h0);
      chk(rd, 32'h30);
      bus(32'h10, 1'b0, 32'h0);
      chk(rd, 32'h0);
      bus(32'h10, 1'b1, 32'h0000_00A9);
      repeat (6) @(posedge mclk);
      chk(32'(osc_run), 32'h1);
      cmd(8'h35);
      cmd(8'hE2);
      chk(32'({reversal_line_count, indicator_mode, lcd_drive_level}), 32'h0000_0520);
      cmd(8'h81);
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      cmd(8'hA8);
      chk(32'({dec_busy, display_off_out}), 32'h0);
      results();
   end
endmodule : lcd_aux_command_decoder_tb
